// ---- waveform_output_steer_shutdown_pkg.sv ----
`default_nettype none

package waveform_output_steer_shutdown_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_OUTPUT_POLARITY_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CLOCK_SOURCE_SELECT     = 8'h04;
  localparam logic [7:0] OFF_DATA_INPUT_SELECT       = 8'h08;
  localparam logic [7:0] OFF_STEERING_CONTROL        = 8'h0C;
  localparam logic [7:0] OFF_SHUTDOWN_CONTROL        = 8'h10;

  // Field positions
  localparam int POL_LSB       = 0;
  localparam int DATA_IN_BIT   = 5;
  localparam int CLK_SEL_BIT   = 0;
  localparam int SELECTOR_LSB  = 0;
  localparam int ROUTE_LSB     = 0;
  localparam int FORCED_LSB    = 4;
  localparam int SHUTDOWN_BIT  = 7;
  localparam int RESTART_BIT   = 6;
  localparam int HALT_BD_LSB   = 4;
  localparam int HALT_AC_LSB   = 2;

  // Values after reset
  localparam logic [3:0] RST_INVERT     = 4'h0;
  localparam logic       RST_CLK_SEL    = 1'b0;
  localparam logic [2:0] RST_SELECTOR   = 3'h0;
  localparam logic [3:0] RST_ROUTE      = 4'h0;
  localparam logic [3:0] RST_FORCED     = 4'h0;
  localparam logic       RST_SHUTDOWN   = 1'b0;
  localparam logic       RST_RESTART    = 1'b0;
  localparam logic [1:0] RST_HALT_LEVEL = 2'h1;

  // Mode field encodings seen by this block
  localparam logic [2:0] MODE_STEER_ASYNC = 3'h0;
  localparam logic [2:0] MODE_STEER_SYNC  = 3'h1;

  // Shutdown level encodings
  typedef enum logic [1:0] {
    HALT_INACTIVE = 2'h0,
    HALT_FLOAT    = 2'h1,
    HALT_LOW      = 2'h2,
    HALT_HIGH     = 2'h3
  } halt_level_t;

  // Restart sequencing, one-hot
  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_HALT  = 3'h2,
    ST_REARM = 3'h4
  } halt_state_t;

  // Per-output settings handed to a lane
  typedef struct packed {
    logic        steer_mode;
    logic        route_enable;
    logic        forced_level;
    logic        invert;
    halt_level_t halt_level;
  } lane_cfg_t;

endpackage

`default_nettype wire

// ---- sync2.sv ----
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  // Asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      meta_reg <= '0;
      o_sync   <= '0;
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ---- output_lane.sv ----
`timescale 1ns/1ps
`default_nettype none

module output_lane (
  // Clock and reset
  input  wire logic                                       i_clk,
  input  wire logic                                       i_rst_b,
  // Settings and waveform
  input  wire waveform_output_steer_shutdown_pkg::lane_cfg_t i_cfg,
  input  wire logic                                       i_data,
  input  wire logic                                       i_mode_wave,
  input  wire logic                                       i_halt,
  input  wire logic                                       i_dead_band_elapsed,
  // Pin drive
  output logic                                            o_level,
  output logic                                            o_drive_en
);

  logic level_next;
  logic drive_next;

  always_comb
  begin
    level_next = o_level;
    drive_next = 1'b1;
    if (i_halt)
    begin
      case (i_cfg.halt_level)
        waveform_output_steer_shutdown_pkg::HALT_HIGH: level_next = 1'b1;
        waveform_output_steer_shutdown_pkg::HALT_LOW:  level_next = 1'b0;
        waveform_output_steer_shutdown_pkg::HALT_FLOAT: drive_next = 1'b0;
        waveform_output_steer_shutdown_pkg::HALT_INACTIVE:
        begin
          // Holds the last level until the dead band has run out
          if (i_dead_band_elapsed)
            level_next = i_cfg.invert;
        end
        default: level_next = o_level;
      endcase
    end
    else if (i_cfg.steer_mode)
    begin
      if (i_cfg.route_enable)
        level_next = i_data ^ i_cfg.invert;
      else
        level_next = i_cfg.forced_level;
    end
    else
      level_next = i_mode_wave ^ i_cfg.invert;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_level    <= 1'b0;
      o_drive_en <= 1'b0;
    end
    else
    begin
      o_level    <= level_next;
      o_drive_en <= drive_next;
    end
  end

endmodule

`default_nettype wire

// ---- waveform_output_steer_shutdown.sv ----
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each output has a polarity bit; set inverts the output, clear keeps it.
// - Read-only bit 5 of the polarity register shows the selected data input.
// - Clock select bit: 1 picks internal fast oscillator, 0 the system clock.
// - Three-bit selector routes one of eight sources to the data input.
// - Steering enabled: output carries data input with its polarity applied.
// - Steering disabled: output is driven to its steering data bit.
// - Steering bits act only in the two steering modes, mode 00x.
// - In synchronous steering mode the steering enables are double-buffered.
// - Shutdown status bit 7 reads 1 while shutdown holds; hardware sets and clears.
// - Restart enable bit 6 allows automatic recovery; clear needs software restart.
// - Level control for B and D: high, low, floating, or inactive after dead band.
// - Level control for A and C uses the same four encodings.
// - Software may write shutdown status to force the override levels.
// - After status clears, outputs stay halted until the next data rising edge.
// - Unimplemented bits read as zero and ignore writes.
// - Software clear of shutdown status is refused while a condition remains.
// - With restart enabled, hardware clears the status once conditions are gone.
// - Every shutdown event that sets the status bit raises the interrupt request flag.
module waveform_output_steer_shutdown (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Data input sources
  input  wire logic        i_remapped_input_pin,
  input  wire logic        i_capcomp_one_output,
  input  wire logic        i_capcomp_two_output,
  input  wire logic        i_pulse_gen_three_output,
  input  wire logic        i_pulse_gen_four_output,
  input  wire logic        i_comparator_one_output,
  input  wire logic        i_comparator_two_output,
  input  wire logic        i_modulator_output,
  // Combined enabled shutdown sources
  input  wire logic        i_shutdown_condition,
  // Mode and dead-band logic
  input  wire logic        i_enable,
  input  wire logic [2:0]  i_mode,
  input  wire logic [3:0]  i_mode_waveform,
  input  wire logic        i_dead_band_elapsed,
  // Output pins
  output logic             o_output_a,
  output logic             o_output_b,
  output logic             o_output_c,
  output logic             o_output_d,
  output logic             o_output_a_en,
  output logic             o_output_b_en,
  output logic             o_output_c_en,
  output logic             o_output_d_en,
  // Status to the rest of the chip
  output logic             o_internal_fast_oscillator,
  output logic             o_data_input,
  output logic             o_shutdown_irq_flag,
  output logic             o_halted
);

  typedef waveform_output_steer_shutdown_pkg::halt_level_t halt_level_t;
  typedef waveform_output_steer_shutdown_pkg::halt_state_t halt_state_t;
  localparam halt_state_t ST_RUN   = waveform_output_steer_shutdown_pkg::ST_RUN;
  localparam halt_state_t ST_HALT  = waveform_output_steer_shutdown_pkg::ST_HALT;
  localparam halt_state_t ST_REARM = waveform_output_steer_shutdown_pkg::ST_REARM;

  // Register state
  logic [3:0]  invert_reg;
  logic        clk_sel_reg;
  logic [2:0]  selector_reg;
  logic [3:0]  route_reg;
  logic [3:0]  route_active_reg;
  logic [3:0]  forced_reg;
  logic        shutdown_reg;
  logic        shutdown_next;
  logic        restart_en_reg;
  logic [1:0]  halt_bd_reg;
  logic [1:0]  halt_ac_reg;

  // Bus state
  logic        addr_phase;
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        wr_polarity;
  logic        wr_clock;
  logic        wr_selector;
  logic        wr_steering;
  logic        wr_shutdown;

  // Waveform state
  logic [8:0]  raw_inputs;
  logic [8:0]  synced;
  logic [7:0]  sources;
  logic        shutdown_cond;
  logic        data_in;
  logic        data_prev_reg;
  logic        data_rise;
  logic        steer_mode;
  halt_state_t state_reg;
  halt_state_t state_next;
  logic        halt;

  logic [3:0]  lane_level;
  logic [3:0]  lane_drive;
  waveform_output_steer_shutdown_pkg::lane_cfg_t lane_cfg [4];

  // All sources may come from other clocks or pins
  assign raw_inputs = {i_shutdown_condition,
                       i_modulator_output,
                       i_comparator_two_output,
                       i_comparator_one_output,
                       i_pulse_gen_four_output,
                       i_pulse_gen_three_output,
                       i_capcomp_two_output,
                       i_capcomp_one_output,
                       i_remapped_input_pin};

  sync2 #(
    .WIDTH (9)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_async (raw_inputs),
    .o_sync  (synced)
  );

  assign sources       = synced[7:0];
  assign shutdown_cond = synced[8];

  assign data_in   = sources[selector_reg];
  assign data_rise = data_in & ~data_prev_reg;
  assign steer_mode = (i_mode[2:1] == 2'b00);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      data_prev_reg <= 1'b0;
    else
      data_prev_reg <= data_in;
  end

  // Bus decode: single-cycle address phase, zero-wait data phase
  assign addr_phase  = i_hsel & i_htrans[1] & i_hready;
  assign wdata       = i_hwdata[7:0];
  assign wr_polarity = wr_pend_reg & (wr_addr_reg == waveform_output_steer_shutdown_pkg::OFF_OUTPUT_POLARITY_CONTROL);
  assign wr_clock    = wr_pend_reg & (wr_addr_reg == waveform_output_steer_shutdown_pkg::OFF_CLOCK_SOURCE_SELECT);
  assign wr_selector = wr_pend_reg & (wr_addr_reg == waveform_output_steer_shutdown_pkg::OFF_DATA_INPUT_SELECT);
  assign wr_steering = wr_pend_reg & (wr_addr_reg == waveform_output_steer_shutdown_pkg::OFF_STEERING_CONTROL);
  assign wr_shutdown = wr_pend_reg & (wr_addr_reg == waveform_output_steer_shutdown_pkg::OFF_SHUTDOWN_CONTROL);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_phase & i_hwrite & (i_haddr[31:8] == 24'h000000);
      if (addr_phase)
        wr_addr_reg <= i_haddr[7:0];
    end
  end

  // Unmapped and unimplemented bits read as zero
  always_comb
  begin
    rdata = 8'h00;
    if (i_haddr[31:8] == 24'h000000)
    begin
      case (i_haddr[7:0])
        waveform_output_steer_shutdown_pkg::OFF_OUTPUT_POLARITY_CONTROL:
        begin
          rdata[waveform_output_steer_shutdown_pkg::POL_LSB +: 4] = invert_reg;
          rdata[waveform_output_steer_shutdown_pkg::DATA_IN_BIT]  = data_in;
        end
        waveform_output_steer_shutdown_pkg::OFF_CLOCK_SOURCE_SELECT:
          rdata[waveform_output_steer_shutdown_pkg::CLK_SEL_BIT] = clk_sel_reg;
        waveform_output_steer_shutdown_pkg::OFF_DATA_INPUT_SELECT:
          rdata[waveform_output_steer_shutdown_pkg::SELECTOR_LSB +: 3] = selector_reg;
        waveform_output_steer_shutdown_pkg::OFF_STEERING_CONTROL:
        begin
          rdata[waveform_output_steer_shutdown_pkg::ROUTE_LSB +: 4]  = route_reg;
          rdata[waveform_output_steer_shutdown_pkg::FORCED_LSB +: 4] = forced_reg;
        end
        waveform_output_steer_shutdown_pkg::OFF_SHUTDOWN_CONTROL:
        begin
          rdata[waveform_output_steer_shutdown_pkg::SHUTDOWN_BIT]     = shutdown_reg;
          rdata[waveform_output_steer_shutdown_pkg::RESTART_BIT]      = restart_en_reg;
          rdata[waveform_output_steer_shutdown_pkg::HALT_BD_LSB +: 2] = halt_bd_reg;
          rdata[waveform_output_steer_shutdown_pkg::HALT_AC_LSB +: 2] = halt_ac_reg;
        end
        default: rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_hrdata    <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end
    else
    begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (addr_phase & ~i_hwrite)
        o_hrdata <= {24'h000000, rdata};
    end
  end

  // Writable fields; bits outside them are dropped
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      invert_reg     <= waveform_output_steer_shutdown_pkg::RST_INVERT;
      clk_sel_reg    <= waveform_output_steer_shutdown_pkg::RST_CLK_SEL;
      selector_reg   <= waveform_output_steer_shutdown_pkg::RST_SELECTOR;
      route_reg      <= waveform_output_steer_shutdown_pkg::RST_ROUTE;
      forced_reg     <= waveform_output_steer_shutdown_pkg::RST_FORCED;
      restart_en_reg <= waveform_output_steer_shutdown_pkg::RST_RESTART;
      halt_bd_reg    <= waveform_output_steer_shutdown_pkg::RST_HALT_LEVEL;
      halt_ac_reg    <= waveform_output_steer_shutdown_pkg::RST_HALT_LEVEL;
    end
    else
    begin
      if (wr_polarity)
        invert_reg <= wdata[waveform_output_steer_shutdown_pkg::POL_LSB +: 4];
      if (wr_clock)
        clk_sel_reg <= wdata[waveform_output_steer_shutdown_pkg::CLK_SEL_BIT];
      if (wr_selector)
        selector_reg <= wdata[waveform_output_steer_shutdown_pkg::SELECTOR_LSB +: 3];
      if (wr_steering)
      begin
        route_reg  <= wdata[waveform_output_steer_shutdown_pkg::ROUTE_LSB +: 4];
        forced_reg <= wdata[waveform_output_steer_shutdown_pkg::FORCED_LSB +: 4];
      end
      if (wr_shutdown)
      begin
        restart_en_reg <= wdata[waveform_output_steer_shutdown_pkg::RESTART_BIT];
        halt_bd_reg    <= wdata[waveform_output_steer_shutdown_pkg::HALT_BD_LSB +: 2];
        halt_ac_reg    <= wdata[waveform_output_steer_shutdown_pkg::HALT_AC_LSB +: 2];
      end
    end
  end

  // Active steering copy: immediate in async mode, period-aligned in sync mode
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      route_active_reg <= waveform_output_steer_shutdown_pkg::RST_ROUTE;
    else if (i_mode == waveform_output_steer_shutdown_pkg::MODE_STEER_ASYNC)
      route_active_reg <= route_reg;
    else if ((i_mode == waveform_output_steer_shutdown_pkg::MODE_STEER_SYNC) && data_rise)
      route_active_reg <= route_reg;
  end

  // Shutdown status; a set in the same cycle as a clear wins
  always_comb
  begin
    shutdown_next = shutdown_reg;
    if (shutdown_cond)
      shutdown_next = 1'b1;
    else if (wr_shutdown && wdata[waveform_output_steer_shutdown_pkg::SHUTDOWN_BIT])
      shutdown_next = 1'b1;
    else if (restart_en_reg)
      shutdown_next = 1'b0;
    else if (wr_shutdown)
      shutdown_next = 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      shutdown_reg        <= waveform_output_steer_shutdown_pkg::RST_SHUTDOWN;
      o_shutdown_irq_flag <= 1'b0;
    end
    else
    begin
      shutdown_reg        <= shutdown_next;
      o_shutdown_irq_flag <= shutdown_next & ~shutdown_reg;
    end
  end

  // Reset starts halted so the first waveform begins on a clean edge
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (shutdown_reg)
          state_next = ST_HALT;
      ST_HALT:
        if (!shutdown_reg)
          state_next = ST_REARM;
      ST_REARM:
        if (shutdown_reg)
          state_next = ST_HALT;
        else if (data_rise)
          state_next = ST_RUN;
      default: state_next = ST_HALT;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      state_reg <= ST_HALT;
    else
      state_reg <= state_next;
  end

  assign halt = (state_reg != ST_RUN);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_internal_fast_oscillator <= waveform_output_steer_shutdown_pkg::RST_CLK_SEL;
      o_data_input               <= 1'b0;
      o_halted                   <= 1'b1;
    end
    else
    begin
      o_internal_fast_oscillator <= clk_sel_reg;
      o_data_input               <= data_in;
      o_halted                   <= halt & i_enable;
    end
  end

  // Lanes 0..3 are outputs A..D; B and D share one level control
  for (genvar g = 0; g < 4; g++)
  begin : g_lane
    always_comb
    begin
      lane_cfg[g].steer_mode   = steer_mode;
      lane_cfg[g].route_enable = route_active_reg[g];
      lane_cfg[g].forced_level = forced_reg[g];
      lane_cfg[g].invert       = invert_reg[g];
      if (g % 2 == 1)
        lane_cfg[g].halt_level = halt_level_t'(halt_bd_reg);
      else
        lane_cfg[g].halt_level = halt_level_t'(halt_ac_reg);
    end

    output_lane u_lane (
      .i_clk               (i_clk),
      .i_rst_b             (i_rst_b),
      .i_cfg               (lane_cfg[g]),
      .i_data              (data_in),
      .i_mode_wave         (i_mode_waveform[g]),
      .i_halt              (halt),
      .i_dead_band_elapsed (i_dead_band_elapsed),
      .o_level             (lane_level[g]),
      .o_drive_en          (lane_drive[g])
    );
  end

  assign o_output_a    = lane_level[0];
  assign o_output_b    = lane_level[1];
  assign o_output_c    = lane_level[2];
  assign o_output_d    = lane_level[3];
  assign o_output_a_en = lane_drive[0];
  assign o_output_b_en = lane_drive[1];
  assign o_output_c_en = lane_drive[2];
  assign o_output_d_en = lane_drive[3];

endmodule

`default_nettype wire

// ---- waveform_output_steer_shutdown_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module waveform_output_steer_shutdown_checker (
  // Bus and control inputs
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        i_shutdown_condition,
  input wire logic        i_enable,
  input wire logic [2:0]  i_mode,
  // Design outputs
  input wire logic        o_output_a,
  input wire logic        o_output_b,
  input wire logic        o_output_c,
  input wire logic        o_output_d,
  input wire logic        o_output_a_en,
  input wire logic        o_output_b_en,
  input wire logic        o_output_c_en,
  input wire logic        o_internal_fast_oscillator,
  input wire logic        o_data_input,
  input wire logic        o_shutdown_irq_flag,
  input wire logic        o_halted
);
  logic       wr_reg;
  logic [7:0] wa_reg;
  logic [3:0] pol_reg;
  logic [7:0] str_reg;
  logic [3:0] lv_reg;
  logic       cs_reg;
  logic [3:0] quiet_reg;
  logic       dp_reg;
  logic       up_reg;
  logic       run_ok;

  // Shadow registers from bus writes; up_reg waits for the resume edge
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      wr_reg <= 1'b0;
      wa_reg <= 8'h00;
      pol_reg <= 4'h0;
      str_reg <= 8'h00;
      lv_reg <= 4'h5;
      cs_reg <= 1'b0;
      quiet_reg <= 4'h0;
      dp_reg <= 1'b0;
      up_reg <= 1'b0;
    end
    else
    begin
      wr_reg <= i_hsel && i_htrans[1] && i_hready && i_hwrite;
      wa_reg <= i_haddr[7:0];
      quiet_reg <= wr_reg ? 4'h0 : quiet_reg + {3'h0, quiet_reg != 4'hF};
      dp_reg <= o_data_input;
      up_reg <= !o_halted && i_enable && (up_reg || (o_data_input && !dp_reg));
      if (wr_reg)
      begin
        case (wa_reg)
          8'h00: pol_reg <= i_hwdata[3:0];
          8'h04: cs_reg <= i_hwdata[0];
          8'h0C: str_reg <= i_hwdata[7:0];
          8'h10: lv_reg <= i_hwdata[5:2];
          default: ;
        endcase
      end
    end
  end

  assign run_ok = i_mode == 3'h0 && i_enable && !o_halted && up_reg && quiet_reg > 4'h3;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_float;
    (o_halted && lv_reg[1:0] == 2'h1 && quiet_reg > 4'h1)[*2];
  endsequence
  sequence s_high;
    (o_halted && lv_reg[1:0] == 2'h3 && quiet_reg > 4'h1)[*2];
  endsequence
  sequence s_low;
    (o_halted && lv_reg[3:2] == 2'h2 && quiet_reg > 4'h1)[*2];
  endsequence

  chk_forced_level:
    assert property ((run_ok && !str_reg[2])[*3] |-> o_output_c == str_reg[6] && o_output_c_en)
    else $error("output c not at forced level");
  chk_routed_wave:
    assert property ((run_ok && str_reg[0] && $stable(o_data_input))[*3]
      |-> o_output_a == (o_data_input ^ pol_reg[0])) else $error("output a not routed");
  chk_halt_float:
    assert property (s_float |-> !o_output_a_en && !o_output_c_en) else $error("a or c driven");
  chk_halt_high:
    assert property (s_high |-> o_output_a && o_output_c && o_output_a_en) else $error("a or c not high");
  chk_halt_low:
    assert property (s_low |-> !o_output_b && !o_output_d && o_output_b_en) else $error("b or d not low");
  chk_cond_halts:
    assert property ((i_enable && i_shutdown_condition)[*8] |-> o_halted) else $error("no halt");
  chk_irq_pulse:
    assert property ($rose(o_shutdown_irq_flag) |=> !o_shutdown_irq_flag) else $error("irq too long");
  chk_clk_select:
    assert property (quiet_reg > 4'h1 |-> o_internal_fast_oscillator == cs_reg) else $error("clock select");
endmodule

`default_nettype wire

// ---- power_stage_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
  // Gate drive from the block
  input  wire logic [3:0] i_level,
  input  wire logic [3:0] i_drive_en,
  // Resolved switch gates
  output logic      [3:0] o_pin
);
  // Gate pull-downs keep a floated switch off, never at its last level
  assign o_pin = i_level & i_drive_en;
endmodule

`default_nettype wire

// ---- waveform_output_steer_shutdown_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module waveform_output_steer_shutdown_tb;
  logic        clk, rst_b, hsel, hwrite, cond, en, dbe;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, q;
  logic [7:0]  src;
  logic [2:0]  mode;
  logic [3:0]  wave;
  wire  [31:0] hrdata;
  wire         hrdy, hresp, osc, din, irq, halted;
  wire  [3:0]  lvl, oe, pin;
  int          miscompares, tests_run, irqs;

  waveform_output_steer_shutdown i_dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_remapped_input_pin(src[0]), .i_capcomp_one_output(src[1]), .i_capcomp_two_output(src[2]),
    .i_pulse_gen_three_output(src[3]), .i_pulse_gen_four_output(src[4]),
    .i_comparator_one_output(src[5]), .i_comparator_two_output(src[6]), .i_modulator_output(src[7]),
    .i_shutdown_condition(cond), .i_enable(en), .i_mode(mode), .i_mode_waveform(wave),
    .i_dead_band_elapsed(dbe), .o_output_a(lvl[0]), .o_output_b(lvl[1]), .o_output_c(lvl[2]),
    .o_output_d(lvl[3]), .o_output_a_en(oe[0]), .o_output_b_en(oe[1]), .o_output_c_en(oe[2]),
    .o_output_d_en(oe[3]), .o_internal_fast_oscillator(osc), .o_data_input(din),
    .o_shutdown_irq_flag(irq), .o_halted(halted)
  );

  power_stage_model i_stage (.i_level(lvl), .i_drive_en(oe), .o_pin(pin));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
    if (irq === 1'b1)
      irqs <= irqs + 1;

  task wrap_up;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task w(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Bounded wait for hready; a stuck bus ends the run
  task wt;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hrdy !== 1'b1 && n < 50);
    if (hrdy !== 1'b1)
    begin
      miscompares++;
      $display("[ERR] %0t bus hang", $time);
      wrap_up();
    end
  endtask

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask

  task rise;
    src[0] <= 1'b0;
    w(4);
    src[0] <= 1'b1;
    w(6);
  endtask

  task t_regs;
    logic [7:0] rv [5];
    logic [7:0] ev [5];
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h14};
    ev = '{8'h0F, 8'h01, 8'h07, 8'hFF, 8'h3C};
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk(q, {24'h0, rv[i]});
      xfer(1'b1, 8'(4 * i), 32'hFFFFFFFF - 32'(8'hFF - (i == 4 ? 8'h3F : 8'hFF)));
      xfer(1'b0, 8'(4 * i), 32'h0);
      chk(q, {24'h0, ev[i]});
    end
    chk(osc, 1'b1);
    for (int i = 0; i < 5; i++)
      xfer(1'b1, 8'(4 * i), {24'h0, rv[i]});
    chk(osc, 1'b0);
    xfer(1'b1, 8'h20, 32'hFFFFFFFF);
    xfer(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    chk(hresp, 1'b0);
  endtask

  task t_select;
    for (int s = 0; s < 8; s++)
    begin
      xfer(1'b1, 8'h08, 32'(s));
      src <= 8'h01 << s;
      w(6);
      chk(din, 1'b1);
      xfer(1'b0, 8'h00, 32'h0);
      chk(q[5], 1'b1);
      src <= ~(8'h01 << s);
      w(6);
      chk(din, 1'b0);
    end
    src <= 8'h00;
    xfer(1'b1, 8'h08, 32'h0);
  endtask

  task t_steer;
    en <= 1'b1;
    xfer(1'b1, 8'h00, 32'h5);
    xfer(1'b1, 8'h0C, 32'h43);
    rise();
    chk(pin, 4'h6);
    src[0] <= 1'b0;
    w(6);
    chk(pin, 4'h5);
    mode <= 3'h2;
    wave <= 4'h3;
    w(4);
    chk(pin, 4'h6);
    mode <= 3'h1;
    xfer(1'b1, 8'h0C, 32'h40);
    w(4);
    chk(pin, 4'h5);
    rise();
    chk(pin, 4'h4);
  endtask

  task t_halt;
    int n;
    mode <= 3'h0;
    xfer(1'b1, 8'h0C, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, 8'h10, 32'h2C);
    n = irqs;
    cond <= 1'b1;
    w(8);
    chk(halted, 1'b1);
    chk(pin, 4'h5);
    chk(irqs, n + 1);
    xfer(1'b1, 8'h10, 32'h2C);
    xfer(1'b0, 8'h10, 32'h0);
    chk(q, 32'hAC);
    cond <= 1'b0;
    w(8);
    xfer(1'b0, 8'h10, 32'h0);
    chk(q, 32'hAC);
    xfer(1'b1, 8'h10, 32'h2C);
    xfer(1'b0, 8'h10, 32'h0);
    chk(q, 32'h2C);
    chk(pin, 4'h5);
    rise();
    chk(pin, 4'h0);
  endtask

  task t_float;
    xfer(1'b1, 8'h10, 32'h74);
    cond <= 1'b1;
    w(8);
    chk(oe, 4'hA);
    chk(pin, 4'hA);
    cond <= 1'b0;
    w(8);
    xfer(1'b0, 8'h10, 32'h0);
    chk(q, 32'h74);
    rise();
    chk(oe, 4'hF);
  endtask

  task t_soft;
    int n;
    en <= 1'b0;
    n = irqs;
    xfer(1'b1, 8'h10, 32'hAC);
    w(6);
    chk(pin, 4'h5);
    chk(irqs, n + 1);
    xfer(1'b1, 8'h00, 32'h3);
    xfer(1'b1, 8'h10, 32'h80);
    w(4);
    chk(pin, 4'h5);
    dbe <= 1'b1;
    w(4);
    chk(pin, 4'h3);
    xfer(1'b1, 8'h10, 32'h0);
    en <= 1'b1;
    dbe <= 1'b0;
    rise();
    chk(pin, 4'h0);
  endtask

  initial
  begin
    {rst_b, hsel, hwrite, cond, en, dbe, htrans, haddr, hwdata, src, mode, wave} = '0;
    {miscompares, tests_run, irqs} = '0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_select();
    t_steer();
    t_halt();
    t_float();
    t_soft();
    wrap_up();
  end
endmodule

bind waveform_output_steer_shutdown waveform_output_steer_shutdown_checker i_chk (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
  .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .i_shutdown_condition(i_shutdown_condition), .i_enable(i_enable), .i_mode(i_mode),
  .o_output_a(o_output_a), .o_output_b(o_output_b), .o_output_c(o_output_c),
  .o_output_d(o_output_d), .o_output_a_en(o_output_a_en), .o_output_b_en(o_output_b_en),
  .o_output_c_en(o_output_c_en), .o_internal_fast_oscillator(o_internal_fast_oscillator),
  .o_data_input(o_data_input), .o_shutdown_irq_flag(o_shutdown_irq_flag), .o_halted(o_halted)
);

`default_nettype wire
